// [verification/cxa_master_model.sv]
// Behavioural model of the three crossbar masters' request lines.
`timescale 1ns/1ps
`default_nettype none
module cxa_master_model (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [2:0] go,
	input wire logic [2:0] cancel,
	input wire logic [2:0] gnt,
	output logic [2:0] req
);
	// A master keeps asking until granted; a route error never grants,
	// so the bench must cancel such a request or it would stay forever.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			req <= 3'h0;
		end else begin
			req <= (req & ~gnt & ~cancel) | go;
		end
	end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the crossbar arbiter.
`timescale 1ns/1ps
`default_nettype none
`include "cxa_map.svh"
module tb;
	import cxa_pkg::*;
	logic ref_clk = 1'b0, rstn = 1'b0;
	logic [2:0] go = 3'h0, cancel = 3'h0, req, gntVec;
	cxa_tgt_t accelTgt = 2'h0, hostTgt = 2'h0, coreTgt = 2'h0;
	cxa_addr_t accelAddr = 20'h0, hostAddr = 20'h0;
	cxa_addr_t dataAAddr = 20'h0, dataBAddr = 20'h0, fetchAddr = 20'h0;
	cxa_word_t accelWdata = 32'h0, hostWdata = 32'h0, memShareWdata;
	logic dataAReq = 1'b0, dataBReq = 1'b0, fetchReq = 1'b0;
	logic accelGnt, hostGnt, coreGnt, hostRouteErr, coreRouteErr;
	cxa_src_t memGnt, memRom, memAddrErr;
	int n_errors = 0, samples_checked = 0;
	assign gntVec = {coreGnt, hostGnt, accelGnt};
	cxa_master_model u_masters (.ref_clk(ref_clk), .rstn(rstn), .go(go),
		.cancel(cancel), .gnt(gntVec), .req(req));
	cxa_crossbar u_dut (.ref_clk(ref_clk), .rstn(rstn),
		.accelReq(req[0]), .accelTgt(accelTgt), .accelAddr(accelAddr),
		.accelWdata(accelWdata), .hostReq(req[1]), .hostTgt(hostTgt),
		.hostAddr(hostAddr), .hostWdata(hostWdata), .coreReq(req[2]),
		.coreTgt(coreTgt), .dataAReq(dataAReq), .dataAAddr(dataAAddr),
		.dataBReq(dataBReq), .dataBAddr(dataBAddr), .fetchReq(fetchReq),
		.fetchAddr(fetchAddr), .accelGnt(accelGnt), .hostGnt(hostGnt),
		.coreGnt(coreGnt), .hostRouteErr(hostRouteErr),
		.coreRouteErr(coreRouteErr), .memGnt(memGnt), .memRom(memRom),
		.memAddrErr(memAddrErr), .memShareWdata(memShareWdata));
	// Free-running core clock, 10 ns period.
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////
	// Inputs move 1 ns after the edge so no race with the sampling edge.
	task automatic step(input int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Bounded wait for one master's grant; a miss ends the run.
	task automatic wait_gnt(input int idx);
		int i;
		for (i = 0; i < 10 && gntVec[idx] !== 1'b1; i++) begin
			step();
		end
		if (gntVec[idx] !== 1'b1) begin
			check("grant wait", 0, 1);
			end_of_test();
		end
	endtask
	// Launch master requests, then look one cycle after they are sampled.
	task automatic launch(input logic [2:0] who);
		go = who;
		step();
		go = 3'h0;
		step();
	endtask
	task automatic flush();
		cancel = 3'h7;
		step();
		cancel = 3'h0;
		step(3);
	endtask
	////////////////////////////////////////////////////////////////////////
	// All three on one target: strict order, loser keeps waiting.
	task automatic t_conflict();
		{accelTgt, hostTgt, coreTgt} = {3{`CXA_TGT_EXT}};
		launch(3'h7);
		check("first grant", gntVec, 3'b001);
		wait_gnt(1);
		check("core during host", coreGnt, 1'b0);
		wait_gnt(2);
		flush();
	endtask
	// Distinct targets are granted in the same cycle.
	task automatic t_parallel();
		accelTgt = `CXA_TGT_MEM;
		accelAddr = 20'h00010;
		accelWdata = 32'hA5C3_0F12;
		hostTgt = `CXA_TGT_EXT;
		coreTgt = `CXA_TGT_PERIPH;
		launch(3'h7);
		check("parallel grants", gntVec, 3'b111);
		check("share grant", memGnt, 4'h1);
		check("share data", memShareWdata, 32'hA5C3_0F12);
		flush();
	endtask
	// Every target code from host and core; missing paths are refused.
	task automatic t_route();
		int c;
		for (c = 0; c < 4; c++) begin
			hostTgt = c[1:0];
			coreTgt = c[1:0];
			launch(3'h6);
			check("host err", hostRouteErr, c == 0 || c == 3);
			check("host gnt", hostGnt, c == 1 || c == 2);
			check("core err", coreRouteErr, c == 1 || c == 3);
			check("core gnt", coreGnt, c == 0);
			check("host mem", memGnt[0], c == 1);
			flush();
		end
	endtask
	// Four memory sources: three slots, ROM flag, bad address skips a slot.
	task automatic t_mem();
		accelTgt = `CXA_TGT_MEM;
		accelAddr = 20'h00100;
		go = 3'h1;
		step();
		go = 3'h0;
		{dataAReq, dataBReq, fetchReq} = 3'b111;
		{dataAAddr, dataBAddr, fetchAddr} = {20'h40000, 20'h3FFFF, 20'h0};
		step();
		{dataAReq, dataBReq, fetchReq} = 3'b000;
		check("mem gnt 4", memGnt, 4'h7);
		check("mem rom 4", memRom, 4'h2);
		flush();
		{dataAReq, dataBReq, fetchReq} = 3'b111;
		{dataAAddr, dataBAddr, fetchAddr} = {20'h9FFFF, 20'hA0000, 20'h40};
		step();
		{dataAReq, dataBReq, fetchReq} = 3'b000;
		check("mem gnt skip", memGnt, 4'hA);
		check("mem err", memAddrErr, 4'h4);
		// The region flag follows the address even where it is refused.
		check("mem rom top", memRom, 4'h6);
		step();
		{dataAReq, dataBReq, fetchReq} = 3'b011;
		{dataAAddr, dataBAddr, fetchAddr} = {20'h0, 20'h5FFFF, 20'h80};
		step();
		{dataAReq, dataBReq, fetchReq} = 3'b000;
		check("mem gnt rom", memGnt, 4'hC);
		check("mem rom data", memRom, 4'h4);
		check("mem err none", memAddrErr, 4'h0);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		step(8);
		check("reset outputs", {gntVec, hostRouteErr, coreRouteErr, memGnt,
			memRom, memAddrErr, memShareWdata}, 0);
		rstn = 1'b1;
		step();
		t_conflict();
		t_parallel();
		t_route();
		t_mem();
		end_of_test();
	end
endmodule
`default_nettype wire

// [verilog/cxa_crossbar.sv]
// Crossbar fixed-priority arbiter with on-chip memory port selector.
`timescale 1ns/1ps
`default_nettype none
`include "cxa_map.svh"
module cxa_crossbar (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic accelReq,
	input wire cxa_pkg::cxa_tgt_t accelTgt,
	input wire cxa_pkg::cxa_addr_t accelAddr,
	input wire cxa_pkg::cxa_word_t accelWdata,
	input wire logic hostReq,
	input wire cxa_pkg::cxa_tgt_t hostTgt,
	input wire cxa_pkg::cxa_addr_t hostAddr,
	input wire cxa_pkg::cxa_word_t hostWdata,
	input wire logic coreReq,
	input wire cxa_pkg::cxa_tgt_t coreTgt,
	input wire logic dataAReq,
	input wire cxa_pkg::cxa_addr_t dataAAddr,
	input wire logic dataBReq,
	input wire cxa_pkg::cxa_addr_t dataBAddr,
	input wire logic fetchReq,
	input wire cxa_pkg::cxa_addr_t fetchAddr,
	output logic accelGnt,
	output logic hostGnt,
	output logic coreGnt,
	output logic hostRouteErr,
	output logic coreRouteErr,
	output cxa_pkg::cxa_src_t memGnt,
	output cxa_pkg::cxa_src_t memRom,
	output cxa_pkg::cxa_src_t memAddrErr,
	output cxa_pkg::cxa_word_t memShareWdata
);
	import cxa_pkg::*;

	cxa_state_s st_r;
	cxa_state_s st_nxt;
	logic [`CXA_NUM_MASTERS-1:0] reqPeriph;
	logic [`CXA_NUM_MASTERS-1:0] reqMem;
	logic [`CXA_NUM_MASTERS-1:0] reqExt;
	logic [`CXA_NUM_MASTERS-1:0] gntPeriph;
	logic [`CXA_NUM_MASTERS-1:0] gntMem;
	logic [`CXA_NUM_MASTERS-1:0] gntExt;
	cxa_src_t memReq;
	cxa_addr_t memAddr [`CXA_NUM_SRC];
	cxa_addr_t shareAddr;

	////////////////////////////////////////////////////////////////////////
	// Per-target request vectors, bit order equals priority order.
	// The host bit of the peripheral vector is tied off: no such path.
	always_comb begin
		reqPeriph[`CXA_M_ACCEL] = accelReq && accelTgt == `CXA_TGT_PERIPH;
		reqPeriph[`CXA_M_HOST] = 1'b0;
		reqPeriph[`CXA_M_CORE] = coreReq && coreTgt == `CXA_TGT_PERIPH;
		reqMem[`CXA_M_ACCEL] = accelReq && accelTgt == `CXA_TGT_MEM;
		reqMem[`CXA_M_HOST] = hostReq && hostTgt == `CXA_TGT_MEM;
		reqMem[`CXA_M_CORE] = 1'b0; // Core reaches memory on its own ports.
		reqExt[`CXA_M_ACCEL] = accelReq && accelTgt == `CXA_TGT_EXT;
		reqExt[`CXA_M_HOST] = hostReq && hostTgt == `CXA_TGT_EXT;
		reqExt[`CXA_M_CORE] = coreReq && coreTgt == `CXA_TGT_EXT;
	end

	// One independent picker per target lets different targets run at once.
	cxa_fixed_prio #(.N(`CXA_NUM_MASTERS)) uPrioPeriph (
		.req(reqPeriph),
		.gnt(gntPeriph)
	);
	cxa_fixed_prio #(.N(`CXA_NUM_MASTERS)) uPrioMem (
		.req(reqMem),
		.gnt(gntMem)
	);
	cxa_fixed_prio #(.N(`CXA_NUM_MASTERS)) uPrioExt (
		.req(reqExt),
		.gnt(gntExt)
	);

	////////////////////////////////////////////////////////////////////////
	// The shared 32-bit memory port carries whichever master won memory.
	assign shareAddr = gntMem[`CXA_M_ACCEL] ? accelAddr : hostAddr;
	always_comb begin
		memReq[`CXA_SRC_SHARE] = |gntMem;
		memReq[`CXA_SRC_DATA_A] = dataAReq;
		memReq[`CXA_SRC_DATA_B] = dataBReq;
		memReq[`CXA_SRC_FETCH] = fetchReq;
		memAddr[`CXA_SRC_SHARE] = shareAddr;
		memAddr[`CXA_SRC_DATA_A] = dataAAddr;
		memAddr[`CXA_SRC_DATA_B] = dataBAddr;
		memAddr[`CXA_SRC_FETCH] = fetchAddr;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state. Memory sources are served in index order, so the shared
	// port (carrying the accelerator or the host) comes first and the fetch port last;
	// a missing request is counted as nothing, an out-of-map one as an error.
	always_comb begin
		logic [2:0] memCnt;
		memCnt = 3'h0;
		st_nxt = st_r;
		st_nxt.accelGnt = gntPeriph[`CXA_M_ACCEL] | gntMem[`CXA_M_ACCEL]
			| gntExt[`CXA_M_ACCEL];
		st_nxt.hostGnt = gntMem[`CXA_M_HOST] | gntExt[`CXA_M_HOST];
		st_nxt.coreGnt = gntPeriph[`CXA_M_CORE] | gntExt[`CXA_M_CORE];
		st_nxt.hostErr = hostReq && (hostTgt == `CXA_TGT_PERIPH
			|| hostTgt > `CXA_TGT_EXT);
		st_nxt.coreErr = coreReq && (coreTgt == `CXA_TGT_MEM
			|| coreTgt > `CXA_TGT_EXT);
		st_nxt.shareData = gntMem[`CXA_M_ACCEL] ? accelWdata : hostWdata;
		for (int i = 0; i < `CXA_NUM_SRC; i++) begin
			st_nxt.memGnt[i] = 1'b0;
			st_nxt.memErr[i] = 1'b0;
			st_nxt.memRom[i] = memAddr[i] >= `CXA_RAM_BYTES;
			if (memReq[i]) begin
				if ({1'b0, memAddr[i]} >= `CXA_MEM_TOP) begin
					st_nxt.memErr[i] = 1'b1;
				end else if (memCnt < `CXA_MEM_MAX_GNT) begin
					st_nxt.memGnt[i] = 1'b1;
					memCnt = memCnt + 3'h1;
				end
			end
		end
	end

	// Everything here sits on the core clock; the peripheral clock domain
	// is outside this block and reaches it through its own crossing.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register.
	assign accelGnt = st_r.accelGnt;
	assign hostGnt = st_r.hostGnt;
	assign coreGnt = st_r.coreGnt;
	assign hostRouteErr = st_r.hostErr;
	assign coreRouteErr = st_r.coreErr;
	assign memGnt = st_r.memGnt;
	assign memRom = st_r.memRom;
	assign memAddrErr = st_r.memErr;
	assign memShareWdata = st_r.shareData;

	////////////////////////////////////////////////////////////////////////
	// Checks. A lower master that loses keeps asking; nothing here
	// promises it will ever win while a higher one keeps requesting.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence accelHostClash;
		accelReq && hostReq && accelTgt == hostTgt
			&& accelTgt != `CXA_TGT_PERIPH && accelTgt <= `CXA_TGT_EXT;
	endsequence
	sequence accelWins;
		accelGnt && !hostGnt;
	endsequence

	AST_HOST_NO_PERIPH: assert property (
		hostReq && hostTgt == `CXA_TGT_PERIPH |=> !hostGnt && hostRouteErr)
		else $error("host port reached a peripheral");
	AST_ACCEL_OVER_HOST: assert property (
		accelHostClash |=> accelWins)
		else $error("accelerator lost to host port");
	AST_HOST_OVER_CORE: assert property (
		!accelReq && hostReq && coreReq && hostTgt == `CXA_TGT_EXT
		&& coreTgt == `CXA_TGT_EXT |=> hostGnt && !coreGnt)
		else $error("core beat host port");
	AST_PARALLEL: assert property (
		accelReq && coreReq && accelTgt == `CXA_TGT_MEM
		&& coreTgt == `CXA_TGT_PERIPH |=> accelGnt && coreGnt)
		else $error("different targets were not granted together");
	AST_ONE_OWNER: assert property (
		accelGnt && coreGnt |-> $past(accelTgt) != $past(coreTgt))
		else $error("two masters own one target");
	AST_MEM_MAX3: assert property (
		$countones(memGnt) <= 3)
		else $error("more than three memory grants");
	AST_MEM_FOURTH_WAITS: assert property (
		accelReq && accelTgt == `CXA_TGT_MEM
		&& {1'b0, accelAddr} < `CXA_MEM_TOP
		&& dataAReq && {1'b0, dataAAddr} < `CXA_MEM_TOP
		&& dataBReq && {1'b0, dataBAddr} < `CXA_MEM_TOP
		&& fetchReq |=> !memGnt[3])
		else $error("fetch granted as fourth source");
	AST_CORE_ONE_CYCLE: assert property (
		dataAReq && {1'b0, dataAAddr} < `CXA_MEM_TOP
		|=> memGnt[1] && !memAddrErr[1])
		else $error("core data access not served next cycle");
	AST_UNIFIED_MAP: assert property (
		fetchReq && !dataAReq && dataBAddr >= `CXA_RAM_BYTES && dataBReq
		&& {1'b0, dataBAddr} < `CXA_MEM_TOP |=> memGnt[2] && memRom[2])
		else $error("ROM data access not served as ROM");
	AST_SHARE_DATA: assert property (
		accelReq && accelTgt == `CXA_TGT_MEM |=> memGnt[0] || memAddrErr[0])
		else $error("shared port did not carry accelerator");

	// The shared port must carry the winner's word, not a stale one;
	// a mux select one cycle late would still pass the grant checks.
	sequence accelToMem;
		accelReq && accelTgt == `CXA_TGT_MEM;
	endsequence

	AST_SHARE_WDATA: assert property (
		accelToMem |=> memShareWdata == $past(accelWdata))
		else $error("shared port carried the wrong write data");
	AST_CORE_NO_MEM: assert property (
		coreReq && coreTgt == `CXA_TGT_MEM |=> coreRouteErr && !coreGnt)
		else $error("core reached memory through the crossbar");
	AST_MAP_TOP: assert property (
		dataBReq && {1'b0, dataBAddr} >= `CXA_MEM_TOP
		|=> memAddrErr[2] && !memGnt[2])
		else $error("access beyond the map was served");
endmodule
`default_nettype wire

// [verilog/cxa_fixed_prio.sv]
// Fixed-priority one-hot picker; bit 0 has the highest priority.
`timescale 1ns/1ps
`default_nettype none
module cxa_fixed_prio #(
	parameter int N = 3
) (
	input wire logic [N-1:0] req,
	output logic [N-1:0] gnt
);
	// Walk from the top down so the lowest set index wins.
	always_comb begin
		gnt = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				gnt = '0;
				gnt[i] = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [verilog/cxa_map.svh]
// Constants for the crossbar and on-chip memory arbiter.
`ifndef CXA_MAP_SVH
`define CXA_MAP_SVH
// Crossbar target codes.
`define CXA_TGT_PERIPH 2'h0
`define CXA_TGT_MEM 2'h1
`define CXA_TGT_EXT 2'h2
`define CXA_TGT_W 2
// Master positions in priority order, highest first.
`define CXA_M_ACCEL 0
`define CXA_M_HOST 1
`define CXA_M_CORE 2
`define CXA_NUM_MASTERS 3
// Memory controller source ports.
`define CXA_SRC_SHARE 0
`define CXA_SRC_DATA_A 1
`define CXA_SRC_DATA_B 2
`define CXA_SRC_FETCH 3
`define CXA_NUM_SRC 4
`define CXA_MEM_MAX_GNT 3'h3
// Port widths of the memory controller.
`define CXA_SHARE_W 32
`define CXA_CORE_DATA_W 64
`define CXA_FETCH_W 256
// Unified map: RAM from zero, ROM right above it.
`define CXA_ADDR_W 20
`define CXA_RAM_BYTES 20'h40000
`define CXA_ROM_BYTES 20'h60000
`define CXA_MEM_TOP 21'h0A0000
`endif

// [verilog/cxa_pkg.sv]
// Types shared by the crossbar arbiter files.
`default_nettype none
package cxa_pkg;
`include "cxa_map.svh"
	typedef logic [`CXA_TGT_W-1:0] cxa_tgt_t;
	typedef logic [`CXA_ADDR_W-1:0] cxa_addr_t;
	typedef logic [`CXA_SHARE_W-1:0] cxa_word_t;
	typedef logic [`CXA_NUM_SRC-1:0] cxa_src_t;
	typedef struct packed {
		logic accelGnt;
		logic hostGnt;
		logic coreGnt;
		logic hostErr;
		logic coreErr;
		cxa_src_t memGnt;
		cxa_src_t memRom;
		cxa_src_t memErr;
		cxa_word_t shareData;
	} cxa_state_s;
endpackage
`default_nettype wire
